// ### jcp_host.sv
// Purpose: scan host driving tck, tms, tdi and test reset
// Assumes: tap idles in run-test state between calls
// Notes: tck stands low outside frames
module jcp_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input logic tdo_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  //////////////////////////////////////////////////
  task tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    o = tdo_line;
    #62.5 tck = 1'b0;
  endtask
  task idle(input int n);
    logic o;
    repeat (n) tick(1'b0, 1'b0, o);
  endtask
  task to_idle;
    logic o;
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask
  // lsb first; last bit leaves shift, then update and back to idle
  // only device on this chain, so no other device needs bypass
  task scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    tick(1'b1, 1'b1, o);
    if (ir) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask
  task test_reset;
    trst_n = 1'b0;
    #100 trst_n = 1'b1;
  endtask
endmodule // jcp_host

// ### jcp_map.vh
// Purpose: constants for the scan configuration port
// Assumes: included by bare name from the design files
// Notes: offsets are byte addresses on the register bus
`ifndef JCP_MAP_VH
`define JCP_MAP_VH

////////////////////////////////////////////////////////////////
// register offsets
`define JCP_ADDR_W 8
`define JCP_OFF_STATUS 8'h00
`define JCP_OFF_CTRL 8'h04
`define JCP_OFF_CFGLEN 8'h08
`define JCP_OFF_BITCNT 8'h0c
`define JCP_OFF_IDCODE 8'h10

////////////////////////////////////////////////////////////////
// fields and reset values
`define JCP_CTRL_START_BIT 0
`define JCP_CFGLEN_RST 32'h00001000
`define JCP_RESP_OKAY 2'b00
`define JCP_RESP_SLVERR 2'b10

////////////////////////////////////////////////////////////////
// instruction codes
`define JCP_IR_W 4
`define JCP_IR_EXTEST 4'h0
`define JCP_IR_PULSE_CFG 4'h1
`define JCP_IR_CFG_LOAD 4'h2
`define JCP_IR_CFG_STAT 4'h3
`define JCP_IR_SAMPLE 4'h5
`define JCP_IR_IDCODE 4'h6
`define JCP_IR_CONFIG_IO 4'hd
`define JCP_IR_BYPASS 4'hf
`define JCP_IR_CAPTURE 4'h1

////////////////////////////////////////////////////////////////
// timing counts
`define JCP_INIT_TCK 11'd1094
`define JCP_NJ_CYCLES 1000

`endif

// ### jcp_sync.v
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are asynchronous to aclk
// Notes: only the second stage is ever read
module jcp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule // jcp_sync

// ### jcp_tap.v
// Purpose: scan test access port that also loads the configuration stream
// Assumes: tck far slower than aclk; every pin passes two flip-flops
// Notes: control and status reachable over an AXI4-Lite slave
// Functional notes
// R1: tms sampled on each rising tck
// R2: state changes on following falling tck
// R3: test reset clears scan logic, no tck
// R4: bypass is one bit, internals untouched
// R5: bypass data reaches tdo one tck later
// R6: host bypasses all other chain devices
// R7: host adds 1094 tck after last bit
// R8: host reads done flag, high means success
// R9: done flag rises after good scan configuration
// R10: scan pins are dedicated, never user io
// R11: bypass, idcode, sample run during serial config
// R12: host interrupts config before other instructions; t_serial sends EXTEST uninterrupted and it runs as bypass
// R13: io-setup interrupts config, frees io buffers
// R14: host reconfigures via trigger or request pin
// R15: chip-wide clear and oe never touch scan
// R16: chain enable held low during scan config
// R17: cascaded chains: ground enable or same order
// R18: reconfig request held high during scan config
// R19: tdi captured on rising tck
// R20: tdo driven only in shift, falling tck
// R21: scan config start ends serial config
// R22: user io high impedance during scan config
// R23: full sixteen-state tap, ir and dr paths
`include "jcp_map.vh"

module jcp_tap #(
  parameter N_IO = 8,
  parameter NJ_CYCLES = `JCP_NJ_CYCLES,
  parameter [31:0] IDCODE = 32'h0000a001 // arbitrary value
) (
  input wire aclk,
  input wire aresetn,
  input wire [`JCP_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`JCP_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  input wire reconfig_req_n,
  input wire chipwide_clear_n,
  input wire chipwide_output_en,
  input wire [N_IO-1:0] core_out,
  input wire core_oe,
  input wire [N_IO-1:0] pin_in,
  output reg [N_IO-1:0] pin_out,
  output reg pin_oe,
  output reg config_done_flag,
  output reg cfg_data_bit,
  output reg cfg_data_valid,
  output wire user_io_hiz
);
  localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PAU_DR = 4'h6, S_EX2_DR = 4'h7;
  localparam [3:0] S_UPD_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb;
  localparam [3:0] S_EX1_IR = 4'hc, S_PAU_IR = 4'hd, S_EX2_IR = 4'he, S_UPD_IR = 4'hf;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [N_IO-1:0] pin_in_s;
  wire tck_s, tms_s, tdi_s, trst_n_s, reconfig_req_n_s, clr_n_s, oe_s;

  jcp_sync #(.W(7), .RST(7'b0011110)) u_sync_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({tck, tms, tdi, trst_n, reconfig_req_n, chipwide_clear_n, chipwide_output_en}),
    .q({tck_s, tms_s, tdi_s, trst_n_s, reconfig_req_n_s, clr_n_s, oe_s})
  );

  jcp_sync #(.W(N_IO)) u_sync_io (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_in),
    .q(pin_in_s)
  );

  ////////////////////////////////////////////////////////////////
  // tck edges and tap reset
  reg tck_d_q;
  wire tck_rise = tck_s & ~tck_d_q;
  wire tck_fall = ~tck_s & tck_d_q;
  // trst acts at once on its synchronised level, whatever tck does
  wire tap_rst = ~aresetn | ~trst_n_s; // [R3]

  always @(posedge aclk) begin
    if (!aresetn)
      tck_d_q <= 1'b0;
    else
      tck_d_q <= tck_s;
  end

  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        S_TLR: tap_next = m ? S_TLR : S_RTI;
        S_RTI: tap_next = m ? S_SEL_DR : S_RTI;
        S_SEL_DR: tap_next = m ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
        S_SH_DR: tap_next = m ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: tap_next = m ? S_UPD_DR : S_PAU_DR;
        S_PAU_DR: tap_next = m ? S_EX2_DR : S_PAU_DR;
        S_EX2_DR: tap_next = m ? S_UPD_DR : S_SH_DR;
        S_UPD_DR: tap_next = m ? S_SEL_DR : S_RTI;
        S_SEL_IR: tap_next = m ? S_TLR : S_CAP_IR;
        S_CAP_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
        S_SH_IR: tap_next = m ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: tap_next = m ? S_UPD_IR : S_PAU_IR;
        S_PAU_IR: tap_next = m ? S_EX2_IR : S_PAU_IR;
        S_EX2_IR: tap_next = m ? S_UPD_IR : S_SH_IR;
        S_UPD_IR: tap_next = m ? S_SEL_DR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // tap state, sampled on rise, moved on fall
  reg [3:0] state_q;
  reg tms_smp_q;
  wire [3:0] state_d = tap_next(state_q, tms_smp_q); // [R23]

  always @(posedge aclk) begin
    if (tap_rst) begin
      state_q <= S_TLR; // [R3]
      tms_smp_q <= 1'b1;
    end else begin
      if (tck_rise)
        tms_smp_q <= tms_s; // [R1]
      if (tck_fall)
        state_q <= state_d; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////
  // instruction register and gating
  reg [`JCP_IR_W-1:0] ir_sh_q;
  reg [`JCP_IR_W-1:0] ir_q;
  reg nj_busy_q;
  // during serial config only bypass, idcode, sample, config-io and cfg-load run, the rest fall back to bypass
  wire ir_allowed = (ir_q == `JCP_IR_BYPASS) | (ir_q == `JCP_IR_IDCODE) | (ir_q == `JCP_IR_SAMPLE) |
                    (ir_q == `JCP_IR_CONFIG_IO) | (ir_q == `JCP_IR_CFG_LOAD);
  wire [`JCP_IR_W-1:0] ir_eff = (nj_busy_q & ~ir_allowed) ? `JCP_IR_BYPASS : ir_q; // [R11]
  wire upd_ir = tck_rise & (state_q == S_UPD_IR);

  always @(posedge aclk) begin
    if (tap_rst) begin
      ir_sh_q <= `JCP_IR_CAPTURE;
      ir_q <= `JCP_IR_IDCODE; // [R3]
    end else if (tck_rise) begin
      case (state_q)
        S_TLR: ir_q <= `JCP_IR_IDCODE;
        S_CAP_IR: ir_sh_q <= `JCP_IR_CAPTURE; // [R23]
        S_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[`JCP_IR_W-1:1]}; // [R19]
        S_UPD_IR: ir_q <= ir_sh_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // data registers
  reg bypass_q;
  reg [31:0] id_sh_q;
  reg [N_IO-1:0] bsr_sh_q;
  reg [N_IO-1:0] bsr_upd_q;
  reg stat_sh_q;
  wire dr_rise = tck_rise & (state_q == S_SH_DR);
  wire cap_dr = tck_rise & (state_q == S_CAP_DR);

  always @(posedge aclk) begin
    if (tap_rst) begin
      bypass_q <= 1'b0;
      id_sh_q <= 32'h00000000;
      bsr_sh_q <= {N_IO{1'b0}};
      bsr_upd_q <= {N_IO{1'b0}};
      stat_sh_q <= 1'b0;
    end else begin
      if (cap_dr) begin
        bypass_q <= 1'b0;
        id_sh_q <= IDCODE;
        bsr_sh_q <= pin_in_s;
        stat_sh_q <= config_done_flag; // [R8]
      end
      if (dr_rise) begin
        case (ir_eff)
          `JCP_IR_IDCODE: id_sh_q <= {tdi_s, id_sh_q[31:1]};
          `JCP_IR_SAMPLE, `JCP_IR_EXTEST, `JCP_IR_CONFIG_IO: bsr_sh_q <= {tdi_s, bsr_sh_q[N_IO-1:1]};
          `JCP_IR_CFG_STAT: stat_sh_q <= tdi_s;
          default: bypass_q <= tdi_s; // [R4] [R19]
        endcase
      end
      if (tck_rise & (state_q == S_UPD_DR) &
          ((ir_eff == `JCP_IR_EXTEST) | (ir_eff == `JCP_IR_CONFIG_IO)))
        bsr_upd_q <= bsr_sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // tdo: driven only in shift states, changed on fall
  reg dr_lsb;

  always @* begin
    case (ir_eff)
      `JCP_IR_IDCODE: dr_lsb = id_sh_q[0];
      `JCP_IR_SAMPLE, `JCP_IR_EXTEST, `JCP_IR_CONFIG_IO: dr_lsb = bsr_sh_q[0];
      `JCP_IR_CFG_STAT: dr_lsb = stat_sh_q;
      default: dr_lsb = bypass_q; // [R5]
    endcase
  end

  always @(posedge aclk) begin
    if (tap_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0; // [R3]
    end else if (tck_fall) begin
      tdo_oe <= (state_d == S_SH_DR) | (state_d == S_SH_IR); // [R20] [R10]
      tdo <= (state_d == S_SH_IR) ? ir_sh_q[0] : dr_lsb; // [R5] [R20]
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration control
  reg [31:0] cfg_len_q;
  reg [31:0] bitcnt_q;
  reg [10:0] init_cnt_q;
  reg cfg_act_q;
  reg init_q;
  reg cfg_intr_q;
  reg [31:0] nj_cnt_q;
  reg req_n_d_q;
  reg sw_start_q;
  wire cfg_bit = dr_rise & cfg_act_q & ~init_q & (ir_eff == `JCP_IR_CFG_LOAD);
  // serial config starts on the rising edge of the request pin, a software write or the pulse-config instruction
  wire nj_start = (reconfig_req_n_s & ~req_n_d_q) | sw_start_q |
                  (upd_ir & (ir_sh_q == `JCP_IR_PULSE_CFG));

  // the configuration state answers to aresetn only; test reset leaves it alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt_q <= 32'h00000000;
      init_cnt_q <= 11'd0;
      cfg_act_q <= 1'b0;
      init_q <= 1'b0;
      cfg_intr_q <= 1'b0;
      nj_busy_q <= 1'b0;
      nj_cnt_q <= 32'h00000000;
      req_n_d_q <= 1'b1;
      config_done_flag <= 1'b0;
      cfg_data_bit <= 1'b0;
      cfg_data_valid <= 1'b0;
    end else begin
      req_n_d_q <= reconfig_req_n_s;
      cfg_data_valid <= cfg_bit;
      if (cfg_bit)
        cfg_data_bit <= tdi_s;
      if (!reconfig_req_n_s) begin
        config_done_flag <= 1'b0;
        nj_busy_q <= 1'b0;
        cfg_act_q <= 1'b0;
        cfg_intr_q <= 1'b0;
      end else if (upd_ir & (ir_sh_q == `JCP_IR_CFG_LOAD)) begin
        nj_busy_q <= 1'b0; // [R21]
        cfg_act_q <= 1'b1;
        init_q <= 1'b0;
        bitcnt_q <= 32'h00000000;
        config_done_flag <= 1'b0;
        cfg_intr_q <= 1'b0;
      end else if (upd_ir & (ir_sh_q == `JCP_IR_CONFIG_IO)) begin
        nj_busy_q <= 1'b0; // [R13]
        cfg_act_q <= 1'b0;
        cfg_intr_q <= nj_busy_q | cfg_act_q; // [R13]
      end else if (nj_start) begin
        nj_busy_q <= 1'b1;
        nj_cnt_q <= 32'h00000000;
        config_done_flag <= 1'b0;
        cfg_intr_q <= 1'b0;
        cfg_act_q <= 1'b0;
      end else begin
        if (nj_busy_q) begin
          nj_cnt_q <= nj_cnt_q + 32'h00000001;
          if (nj_cnt_q == NJ_CYCLES - 1) begin
            nj_busy_q <= 1'b0;
            config_done_flag <= 1'b1;
          end
        end
        if (cfg_bit) begin
          bitcnt_q <= bitcnt_q + 32'h00000001;
          if (bitcnt_q + 32'h00000001 == cfg_len_q) begin
            init_q <= 1'b1;
            init_cnt_q <= 11'd0;
          end
        end
        // device finishes start-up after the extra tck the host supplies
        if (init_q & tck_rise) begin
          init_cnt_q <= init_cnt_q + 11'd1;
          if (init_cnt_q == `JCP_INIT_TCK - 11'd1) begin
            init_q <= 1'b0;
            cfg_act_q <= 1'b0;
            config_done_flag <= 1'b1; // [R9]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // user io; chip-wide pins steer only the core path
  reg [N_IO-1:0] core_hold_q;
  wire bs_drive = (ir_eff == `JCP_IR_EXTEST) | (ir_eff == `JCP_IR_CONFIG_IO);
  assign user_io_hiz = cfg_act_q; // [R22]

  always @(posedge aclk) begin
    if (!aresetn | !clr_n_s)
      core_hold_q <= {N_IO{1'b0}}; // [R15]
    else
      core_hold_q <= core_out;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= {N_IO{1'b0}};
      pin_oe <= 1'b0;
    end else begin
      pin_out <= bs_drive ? bsr_upd_q : core_hold_q; // [R13]
      pin_oe <= ~cfg_act_q & (bs_drive | (oe_s & core_oe & config_done_flag)); // [R22] [R15]
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite slave: write needs address and data together
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `JCP_RESP_OKAY;
      cfg_len_q <= `JCP_CFGLEN_RST;
      sw_start_q <= 1'b0;
    end else begin
      sw_start_q <= 1'b0;
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `JCP_RESP_OKAY;
        case (s_axi_awaddr)
          `JCP_OFF_CTRL: sw_start_q <= s_axi_wstrb[0] & s_axi_wdata[`JCP_CTRL_START_BIT];
          `JCP_OFF_CFGLEN: begin
            if (s_axi_wstrb[0]) cfg_len_q[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) cfg_len_q[15:8] <= s_axi_wdata[15:8];
            if (s_axi_wstrb[2]) cfg_len_q[23:16] <= s_axi_wdata[23:16];
            if (s_axi_wstrb[3]) cfg_len_q[31:24] <= s_axi_wdata[31:24];
          end
          `JCP_OFF_STATUS, `JCP_OFF_BITCNT, `JCP_OFF_IDCODE: s_axi_bresp <= `JCP_RESP_OKAY;
          default: s_axi_bresp <= `JCP_RESP_SLVERR;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `JCP_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `JCP_RESP_OKAY;
      case (s_axi_araddr)
        `JCP_OFF_STATUS: s_axi_rdata <= {20'h00000, user_io_hiz, cfg_intr_q, nj_busy_q,
                                         config_done_flag, ir_q, state_q};
        `JCP_OFF_CTRL: s_axi_rdata <= 32'h00000000;
        `JCP_OFF_CFGLEN: s_axi_rdata <= cfg_len_q;
        `JCP_OFF_BITCNT: s_axi_rdata <= bitcnt_q;
        `JCP_OFF_IDCODE: s_axi_rdata <= IDCODE;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `JCP_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule // jcp_tap

// ### jcp_tap_bench.sv
// Purpose: self-checking bench for the scan configuration port
// Assumes: tck 125 ns, aclk 4 ns, short serial config time
// Notes: released tdo shows the inverse of its last value
`include "jcp_map.vh"
module jcp_tap_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [31:0] ID = 32'h0000b00d; // arbitrary value
  localparam int NJ = 4000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic reconfig_req_n, chipwide_clear_n, chipwide_output_en, core_oe, tdo_line;
  logic [7:0] s_axi_awaddr, s_axi_araddr, core_out, pin_in, pin_out, cfg_sh;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, so;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, pin_oe, config_done_flag, cfg_data_bit, cfg_data_valid, user_io_hiz;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_bits = 0;
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  jcp_tap #(.N_IO(8), .NJ_CYCLES(NJ), .IDCODE(ID)) i_jcp_tap (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .reconfig_req_n, .chipwide_clear_n,
    .chipwide_output_en, .core_out, .core_oe, .pin_in, .pin_out, .pin_oe, .config_done_flag, .cfg_data_bit,
    .cfg_data_valid, .user_io_hiz);
  jcp_host i_jcp_host (.tck, .tms, .tdi, .trst_n, .tdo_line);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cfg_data_valid === 1'b1) n_bits <= n_bits + 1;
    if (cfg_data_valid === 1'b1) cfg_sh <= {cfg_data_bit, cfg_sh[7:1]};
    if (cycles == 90000) begin
      fails++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // both channels of a write go up together; answer read at its handshake edge
  task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    @(posedge aclk);
    while ((we ? s_axi_awready : s_axi_arready) !== 1'b1) @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while ((we ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rs = we ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task status_is(input logic [31:0] mask, input logic [31:0] exp, input string msg);
    axi(1'b0, `JCP_OFF_STATUS, 32'h0);
    chk(rd & mask, exp, msg);
  endtask
  task wait_done;
    repeat (NJ + 100) if (config_done_flag !== 1'b1) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////
  task t_regs;
    status_is(32'h1f0, 32'h060, "reset status");
    axi(1'b0, `JCP_OFF_CFGLEN, 32'h0);
    chk(rd, `JCP_CFGLEN_RST, "length reset");
    axi(1'b0, `JCP_OFF_IDCODE, 32'h0);
    chk(rd, ID, "id register");
    axi(1'b0, 8'h20, 32'h0);
    chk({30'h0, rs}, `JCP_RESP_SLVERR, "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    axi(1'b1, 8'h24, 32'h1);
    chk({30'h0, rs}, `JCP_RESP_SLVERR, "unmapped write");
  endtask
  task t_idcode;
    i_jcp_host.scan(1'b1, `JCP_IR_IDCODE, 4, so);
    chk(so, `JCP_IR_CAPTURE, "ir capture");
    i_jcp_host.scan(1'b0, 32'h0, 32, so);
    chk(so, ID, "id shift");
  endtask
  // chip-wide pins toggled on purpose: the scan result must not move
  task t_bypass;
    @(posedge aclk);
    chipwide_clear_n <= 1'b0;
    chipwide_output_en <= 1'b1;
    i_jcp_host.scan(1'b1, `JCP_IR_BYPASS, 4, so);
    i_jcp_host.scan(1'b0, 32'hb4, 8, so);
    chk(so, 32'h68, "bypass one tck late");
    chk(config_done_flag, 1'b0, "bypass touched state");
    @(posedge aclk);
    chipwide_clear_n <= 1'b1;
    chipwide_output_en <= 1'b0;
  endtask
  task t_serial;
    axi(1'b1, `JCP_OFF_CTRL, 32'h1);
    status_is(32'h200, 32'h200, "serial busy");
    i_jcp_host.scan(1'b1, `JCP_IR_IDCODE, 4, so);
    i_jcp_host.scan(1'b0, 32'h0, 32, so);
    chk(so, ID, "id during config");
    i_jcp_host.scan(1'b1, `JCP_IR_EXTEST, 4, so);
    i_jcp_host.scan(1'b0, 32'hb4, 8, so);
    chk(so, 32'h68, "refused acts as bypass");
    wait_done();
    chk(config_done_flag, 1'b1, "serial completes");
  endtask
  task t_jcfg;
    int n0;
    axi(1'b1, `JCP_OFF_CFGLEN, 32'h8);
    chk({30'h0, rs}, `JCP_RESP_OKAY, "length write");
    axi(1'b1, `JCP_OFF_CTRL, 32'h1);
    i_jcp_host.scan(1'b1, `JCP_IR_CFG_LOAD, 4, so);
    status_is(32'hb00, 32'h800, "scan config start");
    chk({user_io_hiz, pin_oe}, 2'b10, "io released");
    n0 = n_bits;
    i_jcp_host.scan(1'b0, 32'ha5, 8, so);
    chk(n_bits - n0, 8, "config bits");
    chk(cfg_sh, 8'ha5, "config data bits");
    axi(1'b0, `JCP_OFF_BITCNT, 32'h0);
    chk(rd, 32'h8, "bit count");
    i_jcp_host.idle(1094);
    chk({config_done_flag, user_io_hiz}, 2'b10, "scan config done");
    i_jcp_host.scan(1'b1, `JCP_IR_CFG_STAT, 4, so);
    i_jcp_host.scan(1'b0, 32'h0, 1, so);
    chk(so, 32'h1, "done seen by scan");
  endtask
  task t_trst;
    i_jcp_host.scan(1'b1, `JCP_IR_BYPASS, 4, so);
    i_jcp_host.test_reset();
    status_is(32'h1f0, 32'h160, "test reset");
    i_jcp_host.to_idle();
  endtask
  task t_cfgio;
    axi(1'b1, `JCP_OFF_CTRL, 32'h1);
    i_jcp_host.scan(1'b1, `JCP_IR_CONFIG_IO, 4, so);
    status_is(32'h600, 32'h400, "config interrupted");
    i_jcp_host.scan(1'b1, `JCP_IR_EXTEST, 4, so);
    i_jcp_host.scan(1'b0, 32'hc3, 8, so);
    chk(so, 32'h5a, "pins captured");
    chk({pin_oe, pin_out}, 9'h1c3, "boundary drives pins");
    @(posedge aclk);
    reconfig_req_n <= 1'b0;
    repeat (8) @(posedge aclk);
    reconfig_req_n <= 1'b1;
    wait_done();
    chk(config_done_flag, 1'b1, "reconfigured");
    i_jcp_host.scan(1'b1, `JCP_IR_PULSE_CFG, 4, so);
    status_is(32'h300, 32'h200, "trigger starts config");
    wait_done();
    chk(config_done_flag, 1'b1, "trigger completes");
  endtask
  //////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    reconfig_req_n = 1'b1;
    // no chain-enable pin on this block; board holds it low
    chipwide_clear_n = 1'b1;
    chipwide_output_en = 1'b0;
    core_out = 8'h3c;
    core_oe = 1'b1;
    pin_in = 8'h5a;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    i_jcp_host.to_idle();
    t_regs();
    t_idcode();
    t_bypass();
    t_serial();
    t_jcfg();
    t_trst();
    t_cfgio();
    end_of_test();
  end
endmodule // jcp_tap_bench

// ### jcp_tap_sva.sv
// Purpose: port checker for the scan configuration port
// Assumes: one aclk domain, aresetn synchronous
// Notes: tck seen only as a pin level, so scan edges are judged by it
module jcp_tap_sva (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_wvalid,
  input logic s_axi_awready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic tck,
  input logic trst_n,
  input logic tdo,
  input logic tdo_oe,
  input logic pin_oe,
  input logic user_io_hiz,
  input logic config_done_flag,
  input logic cfg_data_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  // tck stays low 15 aclk, so a fall-driven update lands while it is low
  property p_tdo_fall;
    $changed(tdo) |-> !tck;
  endproperty
  property p_oe_fall;
    $changed(tdo_oe) |-> !tck;
  endproperty
  property p_trst;
    !trst_n [*5] |-> !tdo_oe;
  endproperty
  property p_hiz_io;
    user_io_hiz && $past(user_io_hiz) |-> !pin_oe;
  endproperty
  property p_hiz_done;
    user_io_hiz && $past(user_io_hiz) |-> !config_done_flag;
  endproperty
  property p_bits;
    cfg_data_valid |-> user_io_hiz ##1 !cfg_data_valid;
  endproperty
  //////////////////////////////////////////////////
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_rd_answer: assert property (p_rd_answer) else $error("no read response");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved with tck high");
  a_trst: assert property (p_trst) else $error("test reset ignored");
  a_hiz_io: assert property (p_hiz_io) else $error("pin driven in scan config");
  a_hiz_done: assert property (p_hiz_done) else $error("done while io released");
  a_bits: assert property (p_bits) else $error("config bit outside scan config");
endmodule // jcp_tap_sva

bind jcp_tap jcp_tap_sva i_jcp_tap_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_oe(pin_oe),
  .user_io_hiz(user_io_hiz), .config_done_flag(config_done_flag), .cfg_data_valid(cfg_data_valid));
